// ---- verilog/tsio_pkg.sv ----
// Purpose: Shared constants and types of the three-wire serial channel
// Assumes: Core clock of 25 MHz
// Notes:   Offsets do not exist; all control travels on plain ports
package tsio_pkg;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int DATA_W      = 8;
  localparam int FIFO_DEPTH  = 8;
  localparam int CLK_NS      = 40;
  localparam int SCK_HALF_NS = 160;
  // Least half period, rounded up to whole core cycles
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  // Edge index of the sixteenth serial clock edge of a word
  localparam logic [4:0] LAST_EDGE = 5'h0F;

  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  localparam logic [2:0] CKS_EXTERNAL = 3'h7;
  localparam logic       SO_RESET     = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b10
  } tsio_state_t;

  // Mode and clock selection bits as software sets them
  typedef struct packed {
    logic       channel_enable;
    logic       transfer_mode_select;
    logic       slave_select_enable;
    logic       bit_order_select;
    logic       data_phase_select;
    logic       clock_polarity_select;
    logic [2:0] clock_source_sel;
  } tsio_cfg_t;

endpackage

// ---- verilog/tsio_fifo.sv ----
// Purpose: Word FIFO in front of the transmit buffer
// Assumes: DEPTH is a power of two
// Notes:   Flags are registered; memory carries no reset
`timescale 1ns/100ps
`default_nettype none
module tsio_fifo #(
  parameter int WIDTH = tsio_pkg::DATA_W,
  parameter int DEPTH = tsio_pkg::FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  input  wire logic             out_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
    logic          rdy;
    logic          vld;
  } tsio_fifo_st_t;

  tsio_fifo_st_t    s;
  tsio_fifo_st_t    n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // Pointer and count update
  always_comb begin
    n    = s;
    push = in_valid & s.rdy;
    pop  = out_ready & s.vld;
    if (push) begin
      n.wr = s.wr + AW'(1);
    end
    if (pop) begin
      n.rd = s.rd + AW'(1);
    end
    n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    n.rdy = n.cnt != (AW+1)'(DEPTH);
    n.vld = n.cnt != '0;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s     <= '0;
      s.rdy <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[s.wr] <= in_data;
    end
  end

  assign in_ready  = s.rdy;
  assign out_valid = s.vld;
  assign out_data  = mem[s.rd];

endmodule
`default_nettype wire

// ---- verilog/tsio_three_wire.sv ----
// Purpose: Three-wire clocked serial channel, master or slave
// Assumes: Serial clock sampled by clk; master half period >= 2 clk
// Notes:   Words come from a FIFO; reception read from rx_data
//
// Behaviour
// - Words are 8 bits, each bit moved on a serial clock edge.
// - Transmit mode: a buffer write starts a combined send and receive.
// - Receive mode: a shift register read starts a reception.
// - Slave with select enabled starts only while select is low.
// - Trigger during select high waits until select goes low.
// - Select going high mid-word suspends the transfer.
// - Busy flag set once a transfer starts.
// - Word end sets done flag, clears busy, allows next transfer.
// - Phase 0: first bit from buffer driven on leading edge.
// - Next edge loads buffer into shifter, shifts, samples first bit.
// - Phase 0: later bits output from shifter on leading edges.
// - Phase 1: first bit driven at the trigger, before any clock.
// - Phase 1: load and sample on first edge, output on opposite.
// - After a word the serial output keeps the last bit.
// - Disabled: output low, or buffer end bit in transmit phase 1.
// - Enabled: low when receiving only, data when transmitting.
// - Mode bit writes update the serial output level at once.
// - Pins unused by the chosen mode stay free as ports.
// - Clearing enable stops and clears busy and shift register.
// - Reset clears every core register to zero; mode bits come in on cfg.
`timescale 1ns/100ps
`default_nettype none
module tsio_three_wire #(
  parameter int HALF_CYC = tsio_pkg::SCK_HALF_CYC,
  parameter int DEPTH    = tsio_pkg::FIFO_DEPTH
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire tsio_pkg::tsio_cfg_t    cfg,
  input  wire logic                   tx_valid,
  input  wire logic [7:0]             tx_data,
  output logic                        tx_ready,
  input  wire logic                   rx_read,
  output logic [7:0]                  rx_data,
  input  wire logic                   done_clear,
  output logic                        transfer_busy_flag,
  output logic                        transfer_done_irq_flag,
  input  wire logic                   serial_clock_pin_i,
  output logic                        serial_clock_pin_o,
  output logic                        serial_clock_pin_oe,
  input  wire logic                   serial_in_pin,
  output logic                        serial_out_pin,
  output logic                        serial_out_pin_oe,
  input  wire logic                   slave_select_input_n
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0]            sck_sy;
    logic [2:0]            ssn_sy;
    logic [2:0]            si_sy;
    logic                  sck_f;
    logic                  ssn_f;
    logic                  si_f;
    logic                  lvl_p;
    tsio_pkg::tsio_state_t st;
    logic [4:0]            hcnt;
    logic [7:0]            div;
    logic                  sck_q;
    logic [7:0]            shift;
    logic [7:0]            tbuf;
    logic                  so_q;
    logic                  busy;
    logic                  done;
    logic                  pin_so;
    logic                  pin_so_oe;
    logic                  pin_sck;
    logic                  pin_sck_oe;
  } tsio_core_st_t;

  tsio_core_st_t s;
  tsio_core_st_t n;

  logic       slave;
  logic       idle_lvl;
  logic       ss_block;
  logic       lvl;
  logic       live;
  logic       lead;
  logic       trail;
  logic       smp;
  logic       outp;
  logic       first_smp;
  logic       trig;
  logic       done_set;
  logic       fifo_pop;
  logic       fifo_valid;
  logic [7:0] fifo_data;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Bit that leaves first for the chosen order
  function automatic logic first_bit(
    input logic [7:0] v,
    input logic       lsb
  );
    return lsb ? v[0] : v[7];
  endfunction

  // One shift with a new received bit entering
  function automatic logic [7:0] shift_in(
    input logic [7:0] v,
    input logic       b,
    input logic       lsb
  );
    return lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // ****************************************************************
  // Transmit word queue
  // ****************************************************************
  tsio_fifo #(
    .WIDTH (tsio_pkg::DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (tx_valid),
    .in_data   (tx_data),
    .in_ready  (tx_ready),
    .out_ready (fifo_pop),
    .out_valid (fifo_valid),
    .out_data  (fifo_data)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n = s;

    // Pin synchronisers, value taken once stages two and three agree
    n.sck_sy = {s.sck_sy[1:0], serial_clock_pin_i};
    n.ssn_sy = {s.ssn_sy[1:0], slave_select_input_n};
    n.si_sy  = {s.si_sy[1:0], serial_in_pin};
    if (s.sck_sy[1] == s.sck_sy[2]) begin
      n.sck_f = s.sck_sy[2];
    end
    if (s.ssn_sy[1] == s.ssn_sy[2]) begin
      n.ssn_f = s.ssn_sy[2];
    end
    if (s.si_sy[1] == s.si_sy[2]) begin
      n.si_f = s.si_sy[2];
    end

    // Mode decode
    slave    = cfg.clock_source_sel == tsio_pkg::CKS_EXTERNAL;
    idle_lvl = ~cfg.clock_polarity_select;
    ss_block = slave & cfg.slave_select_enable & s.ssn_f;

    // Serial clock edges, own divider or sampled pin
    lvl     = slave ? s.sck_f : s.sck_q;
    n.lvl_p = lvl;
    live    = (s.st == tsio_pkg::ST_RUN) & ~ss_block;
    lead    = live & (s.lvl_p == idle_lvl) & (lvl != idle_lvl);
    trail   = live & (s.lvl_p != idle_lvl) & (lvl == idle_lvl);
    smp     = cfg.data_phase_select ? lead : trail;
    outp    = cfg.data_phase_select ? trail : lead;
    first_smp = cfg.data_phase_select ? (s.hcnt == 5'h00)
                                      : (s.hcnt == 5'h01);

    // Start triggers
    fifo_pop = (s.st == tsio_pkg::ST_IDLE) & cfg.channel_enable
             & cfg.transfer_mode_select;
    trig = (fifo_pop & fifo_valid)
         | ((s.st == tsio_pkg::ST_IDLE) & cfg.channel_enable
            & ~cfg.transfer_mode_select & rx_read);
    done_set = 1'b0;

    // Transfer sequencer
    case (s.st)
      tsio_pkg::ST_IDLE: begin
        n.sck_q = idle_lvl;
        n.div   = 8'h00;
        if (trig) begin
          n.busy = 1'b1;
          n.hcnt = 5'h00;
          if (cfg.transfer_mode_select) begin
            n.tbuf = fifo_data;
            if (cfg.data_phase_select) begin
              n.so_q = first_bit(fifo_data,
                                 cfg.bit_order_select);
            end
          end
          // Pending until select falls
          n.st = ss_block ? tsio_pkg::ST_HOLD
                          : tsio_pkg::ST_RUN;
        end
      end
      tsio_pkg::ST_HOLD: begin
        if (!ss_block) begin
          n.st = tsio_pkg::ST_RUN;
        end
      end
      tsio_pkg::ST_RUN: begin
        if (ss_block) begin
          n.st = tsio_pkg::ST_HOLD;
        end else begin
          // Master half period divider
          if (!slave) begin
            if (s.div == 8'(HALF_CYC - 1)) begin
              n.div = 8'h00;
              if (s.hcnt <= tsio_pkg::LAST_EDGE) begin
                n.sck_q = ~s.sck_q;
              end
            end else begin
              n.div = s.div + 8'h01;
            end
          end
          // Output edge
          if (outp) begin
            if (!cfg.data_phase_select && s.hcnt == 5'h00) begin
              n.so_q = first_bit(s.tbuf,
                                 cfg.bit_order_select);
            end else if (s.hcnt != tsio_pkg::LAST_EDGE) begin
              n.so_q = first_bit(s.shift,
                                 cfg.bit_order_select);
            end
          end
          // Sample edge
          if (smp) begin
            n.shift = shift_in(first_smp ? s.tbuf : s.shift,
                               s.si_f,
                               cfg.bit_order_select);
          end
          // Word end after sixteen edges
          if (lead | trail) begin
            n.hcnt = s.hcnt + 5'h01;
            if (s.hcnt == tsio_pkg::LAST_EDGE) begin
              n.st     = tsio_pkg::ST_IDLE;
              n.busy   = 1'b0;
              done_set = 1'b1;
              n.sck_q  = idle_lvl;
            end
          end
        end
      end
      default: begin
        n.st = tsio_pkg::ST_IDLE;
      end
    endcase

    // Disable stops and clears the engine
    if (!cfg.channel_enable) begin
      n.st    = tsio_pkg::ST_IDLE;
      n.busy  = 1'b0;
      n.shift = 8'h00;
      n.hcnt  = 5'h00;
      n.div   = 8'h00;
      n.so_q  = tsio_pkg::SO_RESET;
      n.sck_q = idle_lvl;
    end

    // Done flag, a new word end beats a clear
    n.done = (s.done & ~done_clear) | done_set;

    // Serial output selection, follows mode bits at once
    if (!cfg.channel_enable) begin
      n.pin_so = cfg.transfer_mode_select & cfg.data_phase_select
               & first_bit(n.tbuf, cfg.bit_order_select);
    end else begin
      n.pin_so = cfg.transfer_mode_select & n.so_q;
    end

    // Pin drivers, unused pins left to the port logic
    n.pin_so_oe  = cfg.channel_enable
                 & cfg.transfer_mode_select;
    n.pin_sck    = slave ? idle_lvl : n.sck_q;
    n.pin_sck_oe = cfg.channel_enable & ~slave;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from flops
  assign rx_data                = s.shift;
  assign transfer_busy_flag     = s.busy;
  assign transfer_done_irq_flag = s.done;
  assign serial_out_pin         = s.pin_so;
  assign serial_out_pin_oe      = s.pin_so_oe;
  assign serial_clock_pin_o     = s.pin_sck;
  assign serial_clock_pin_oe    = s.pin_sck_oe;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_busy_on_start:
    assert property (trig |=> s.busy)
    else $error("busy not set at start");

  a_rx_read_start:
    assert property ((s.st == tsio_pkg::ST_IDLE) && cfg.channel_enable
                     && !cfg.transfer_mode_select && rx_read
                     |=> s.busy && s.st != tsio_pkg::ST_IDLE)
    else $error("read did not start reception");

  a_word_end:
    assert property (live && (lead || trail) && cfg.channel_enable
                     && s.hcnt == tsio_pkg::LAST_EDGE
                     |=> s.done && !s.busy
                         && s.st == tsio_pkg::ST_IDLE)
    else $error("word end not flagged");

  a_hold_pending:
    assert property (s.st != tsio_pkg::ST_RUN && ss_block
                     && cfg.channel_enable
                     |=> s.st != tsio_pkg::ST_RUN)
    else $error("start while select high");

  a_suspend_run:
    assert property (s.st == tsio_pkg::ST_RUN && ss_block
                     && cfg.channel_enable
                     |=> s.st == tsio_pkg::ST_HOLD && $stable(s.hcnt))
    else $error("transfer not suspended");

  a_phase1_first:
    assert property (trig && cfg.transfer_mode_select
                     && cfg.data_phase_select
                     |=> s.so_q == first_bit(s.tbuf,
                                   $past(cfg.bit_order_select)))
    else $error("first bit not latched at trigger");

  a_last_bit_hold:
    assert property (s.st == tsio_pkg::ST_IDLE && !trig
                     && cfg.channel_enable |=> $stable(s.so_q))
    else $error("idle output changed");

  a_disable_clear:
    assert property (!cfg.channel_enable
                     |=> !s.busy && s.shift == 8'h00 && s.hcnt == 5'h00)
    else $error("disable did not clear engine");

  a_stop_low:
    assert property (!cfg.channel_enable
                     && !(cfg.transfer_mode_select
                          && cfg.data_phase_select)
                     |=> !serial_out_pin)
    else $error("stopped output not low");

  a_rx_out_low:
    assert property (cfg.channel_enable && !cfg.transfer_mode_select
                     |=> !serial_out_pin && !serial_out_pin_oe)
    else $error("receive only output not low");

  c_tx_word:
    cover property (trig && cfg.transfer_mode_select ##[1:1000] done_set);
  c_suspend:
    cover property (s.st == tsio_pkg::ST_RUN ##1
                    s.st == tsio_pkg::ST_HOLD);
  c_phase1_word:
    cover property (cfg.data_phase_select && done_set);

endmodule
`default_nettype wire

// ---- tb/tsio_peer.sv ----
// Purpose: Far-side peer of the three-wire channel
// Assumes: Idle clock level is the inverse of the polarity bit
// Notes:   Samples 150 ns after each sample edge
`timescale 1ns/100ps
`default_nettype none
module tsio_peer (
  input  wire logic sck,
  input  wire logic so,
  input  wire logic cpol,
  input  wire logic dap,
  input  wire logic lsb,
  input  wire logic sel_n,
  output logic      si,
  output logic      sck_drv
);
  logic [7:0] tx_w  = 8'h00;
  logic [7:0] rx_w  = 8'h00;
  int         n_smp = 0;
  logic       live  = 1'b0;

  // ****************************************************************
  // Control
  // ****************************************************************
  // Load a word, first bit shown before any clock
  task automatic start(input logic [7:0] w);
    tx_w  = w;
    rx_w  = 8'h00;
    n_smp = 0;
    live  = 1'b1;
    si    = lsb ? w[0] : w[7];
  endtask

  // Clock pulses from the idle level, slave runs only
  task automatic pulses(input int n);
    repeat (n) begin
      #160 sck_drv = cpol;
      #160 sck_drv = ~cpol;
    end
  endtask

  // Idle levels at time zero
  initial begin
    si      = 1'b0;
    sck_drv = 1'b1;
  end

  // ****************************************************************
  // Shifting
  // ****************************************************************
  // Sample on the sample edge, present next bit on the other edge
  always @(sck) begin
    if (live && !sel_n) begin
      if ((sck == cpol) == dap) begin
        #150;
        rx_w  = lsb ? {so, rx_w[7:1]} : {rx_w[6:0], so};
        n_smp = n_smp + 1;
        if (n_smp == 8) begin
          live = 1'b0;
          si   = ~si; // Released line shows inverse
        end
      end else if (n_smp < 8) begin
        si = lsb ? tx_w[n_smp] : tx_w[7-n_smp];
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/tsio_three_wire_test.sv ----
// Purpose: Self-checking bench of the three-wire channel
// Assumes: Half serial period of 4 core cycles
// Notes:   Config changed only while idle, except the abort case
`timescale 1ns/100ps
`default_nettype none
module tsio_three_wire_test;
  logic                clk        = 1'b0;
  logic                arst_n     = 1'b0;
  tsio_pkg::tsio_cfg_t cfg        = '0;
  logic                tx_valid   = 1'b0;
  logic [7:0]          tx_data    = 8'h00;
  logic                rx_read    = 1'b0;
  logic                done_clear = 1'b0;
  logic                sel_n      = 1'b0;
  logic                tx_ready, busy, done, sck_o, sck_oe;
  logic                so, so_oe, si, sck_p, sck;
  logic [7:0]          rx_data;
  logic [7:0]          wbuf [8];
  logic [7:0]          pbuf [8];
  int                  fails      = 0;
  int                  n_compared = 0;

  // Wire level of the serial clock pin
  assign sck = sck_oe ? sck_o : sck_p;

  tsio_three_wire tsio_three_wire_inst (
    .clk(clk), .arst_n(arst_n), .cfg(cfg), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_read(rx_read),
    .rx_data(rx_data), .done_clear(done_clear),
    .transfer_busy_flag(busy), .transfer_done_irq_flag(done),
    .serial_clock_pin_i(sck), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe(sck_oe), .serial_in_pin(si),
    .serial_out_pin(so), .serial_out_pin_oe(so_oe),
    .slave_select_input_n(sel_n));

  tsio_peer tsio_peer_inst (
    .sck(sck), .so(so), .cpol(cfg.clock_polarity_select),
    .dap(cfg.data_phase_select), .lsb(cfg.bit_order_select),
    .sel_n(sel_n), .si(si), .sck_drv(sck_p));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Core clock, 40 ns
  initial forever #20 clk = ~clk;

  task automatic give_verdict;
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic cmp_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic last_bit(input logic [7:0] w, input logic l);
    return l ? w[7] : w[0];
  endfunction

  function automatic logic first_bit(input logic [7:0] w, input logic l);
    return l ? w[0] : w[7];
  endfunction

  // Mode bits en,tmd,sse,dir,dap,cpol then clock source
  function automatic tsio_pkg::tsio_cfg_t mk(input logic [5:0] m,
                                             input logic [2:0] cks);
    return {m, cks};
  endfunction

  task automatic set_cfg(input tsio_pkg::tsio_cfg_t c);
    @(negedge clk);
    cfg = c; // Only while idle
    repeat (2) @(negedge clk);
  endtask

  task automatic push(input logic [7:0] w);
    @(negedge clk);
    tx_valid = 1'b1;
    tx_data  = w;
    @(negedge clk);
    tx_valid = 1'b0;
  endtask

  // Wait for word end, check both directions, clear the flag
  task automatic finish_word(input logic [7:0] tx, input logic [7:0] p,
                             input logic so_e);
    int k;
    k = 0;
    while (done !== 1'b1 && k < 600) begin
      @(negedge clk);
      k++;
    end
    cmp_bit("done", 1'b1, done);
    cmp_bit("busy", 1'b0, busy);
    cmp_byte("rx_data", p, rx_data);
    done_clear = 1'b1;
    @(negedge clk);
    done_clear = 1'b0;
    repeat (3) @(negedge clk);
    cmp_byte("peer_rx", tx, tsio_peer_inst.rx_w);
    cmp_bit("so_hold", so_e, so);
    cmp_bit("done_clr", 1'b0, done);
  endtask

  // Watchdog
  initial begin
    #2000000;
    fails++;
    give_verdict();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    tsio_pkg::tsio_cfg_t c;
    logic [7:0]          w;
    logic [7:0]          p;
    void'($urandom(32'h70E9));
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    cmp_bit("busy_rst", 1'b0, busy);
    cmp_bit("done_rst", 1'b0, done);
    cmp_bit("so_rst", 1'b0, so);
    cmp_bit("ready_rst", 1'b1, tx_ready);
    cmp_byte("rx_rst", 8'h00, rx_data);
    // Master words over every order, phase and polarity
    for (int t = 0; t < 8; t++) begin
      c = mk({3'b110, t[0], t[1], t[2]}, 3'($urandom_range(6, 0)));
      set_cfg(c);
      w = 8'($urandom);
      p = 8'($urandom);
      tsio_peer_inst.start(p);
      cmp_bit("sck_oe", 1'b1, sck_oe);
      cmp_bit("sck_idle", ~t[2], sck_o);
      cmp_bit("so_oe", 1'b1, so_oe);
      push(w);
      repeat (2) @(negedge clk);
      cmp_bit("busy", 1'b1, busy);
      repeat (2) @(negedge clk);
      if (t[1]) cmp_bit("so_first", first_bit(w, t[0]), so);
      finish_word(w, p, last_bit(w, t[0]));
    end
    // Fill while disabled, then drain back to back
    set_cfg(mk(6'b010010, 3'h0));
    cmp_bit("so_off_dap", w[7], so);
    set_cfg(mk(6'b010000, 3'h0));
    cmp_bit("so_off", 1'b0, so);
    cmp_bit("sck_oe_off", 1'b0, sck_oe);
    for (int i = 0; i < 8; i++) begin
      wbuf[i] = 8'($urandom);
      pbuf[i] = 8'($urandom);
      cmp_bit("tx_ready", 1'b1, tx_ready);
      push(wbuf[i]);
    end
    cmp_bit("tx_full", 1'b0, tx_ready);
    push(8'hA5);
    tsio_peer_inst.start(pbuf[0]);
    set_cfg(mk(6'b110000, 3'h0));
    for (int i = 0; i < 8; i++) begin
      finish_word(wbuf[i], pbuf[i], last_bit(wbuf[i], 1'b0));
      if (i < 7) tsio_peer_inst.start(pbuf[i+1]);
    end
    cmp_bit("drained", 1'b1, tx_ready);
    cmp_bit("no_extra", 1'b0, busy);
    // Receive only, both orders, started by a read
    for (int t = 0; t < 2; t++) begin
      set_cfg(mk({3'b100, t[0], 2'b00}, 3'h1));
      p = 8'($urandom);
      tsio_peer_inst.start(p);
      cmp_bit("so_rx", 1'b0, so);
      cmp_bit("so_oe_rx", 1'b0, so_oe);
      @(negedge clk);
      rx_read = 1'b1;
      @(negedge clk);
      rx_read = 1'b0;
      finish_word(8'h00, p, 1'b0);
    end
    // Slave with select: held, suspended, resumed
    sel_n = 1'b1;
    set_cfg(mk(6'b111000, 3'h7));
    cmp_bit("sck_oe_sl", 1'b0, sck_oe);
    w = 8'($urandom);
    p = 8'($urandom);
    tsio_peer_inst.start(p);
    push(w);
    tsio_peer_inst.pulses(2);
    repeat (10) @(negedge clk);
    cmp_bit("held", 1'b0, done);
    sel_n = 1'b0;
    repeat (10) @(negedge clk);
    tsio_peer_inst.pulses(4);
    repeat (6) @(negedge clk);
    sel_n = 1'b1;
    repeat (10) @(negedge clk);
    tsio_peer_inst.pulses(4);
    repeat (4) @(negedge clk);
    cmp_bit("susp_done", 1'b0, done);
    cmp_bit("susp_busy", 1'b1, busy);
    sel_n = 1'b0;
    repeat (10) @(negedge clk);
    tsio_peer_inst.pulses(4);
    finish_word(w, p, last_bit(w, 1'b0));
    // Disable in mid-word
    set_cfg(mk(6'b110000, 3'h2));
    tsio_peer_inst.start(8'($urandom));
    push(8'($urandom));
    repeat (30) @(negedge clk);
    cfg.channel_enable = 1'b0;
    repeat (2) @(negedge clk);
    cmp_bit("abort_busy", 1'b0, busy);
    cmp_byte("abort_rx", 8'h00, rx_data);
    cmp_bit("abort_done", 1'b0, done);
    give_verdict();
  end
endmodule
`default_nettype wire
